// >>> rtl/spsync_top.sv
// Synchronous serial unit: registers, clock, transmitter and receiver
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Parity error flag set on receive mismatch
// - Transmit end high while disabled or drained
// - Transmit end cleared by empty-clear or data write
// - Receive multiprocessor bit read-only, kept on disable
// - Transmit multiprocessor bit is read/write storage
// - Eight data bits per character, LSB first
// - Transmit data changes on falling clock edge
// - Receive data sampled on rising clock edge
// - Line keeps MSB level after the character
// - No parity or multiprocessor bit sent
// - Independent transmitter and receiver, one clock
// - Double-buffered transmit and receive paths
// - Clock from internal divider or clock pin
// - Internal clock: eight pulses, idle high
module spsync_top (
   input  wire logic                            ref_clk_i,
   input  wire logic                            rst_i,
   input  wire logic [spsync_pkg::ADDR_W-1:0]   addr_i,
   input  wire logic [spsync_pkg::DATA_W-1:0]   wdata_i,
   input  wire logic                            wr_i,
   input  wire logic                            rd_i,
   output logic      [spsync_pkg::DATA_W-1:0]   rdata_o,
   output logic                                 txd_o,
   input  wire logic                            rxd_i,
   input  wire logic                            sck_i,
   output logic                                 sck_o,
   output logic                                 sck_oe_o,
   output logic                                 irq_o
);

   // ************************************************************
   // Declarations
   // ************************************************************
   spsync_pkg::spsync_ctrl_t     ctrl_reg;
   spsync_pkg::spsync_mode_t     mode_reg;
   spsync_pkg::spsync_tx_state_t tx_state_reg;
   logic [7:0]                   baud_reg;
   logic [7:0]                   div_reg;
   logic [7:0]                   tdr_reg;
   logic [7:0]                   rdr_reg;
   logic [7:0]                   tx_shift_reg;
   logic [7:0]                   rx_shift_reg;
   logic [7:0]                   rx_byte;
   logic [7:0]                   rdata_reg;
   logic [7:0]                   status;
   logic [2:0]                   tx_cnt_reg;
   logic [2:0]                   rx_cnt_reg;
   logic [spsync_pkg::NFLAG-1:0] flag_reg;
   logic [spsync_pkg::NFLAG-1:0] seen_reg;
   logic [spsync_pkg::NFLAG-1:0] flag_set;
   logic [spsync_pkg::NFLAG-1:0] flag_hw_clr;
   logic [spsync_pkg::NFLAG-1:0] flag_sw_clr;
   logic [spsync_pkg::NIRQ-1:0]  istat_reg;
   logic [spsync_pkg::NIRQ-1:0]  imask_reg;
   logic [spsync_pkg::NIRQ-1:0]  irq_ev;
   logic                         tx_end_flag_reg;
   logic                         rx_multiproc_bit_reg;
   logic                         tx_multiproc_bit_reg;
   logic                         txd_reg;
   logic                         sck_reg;
   logic                         sck_oe_reg;
   logic                         irq_reg;
   logic                         rxd_s1_reg;
   logic                         rxd_s2_reg;
   logic                         sck_s1_reg;
   logic                         sck_s2_reg;
   logic                         sck_s3_reg;
   logic                         int_clk;
   logic                         burst_req;
   logic                         div_done;
   logic                         fall_ev;
   logic                         rise_ev;
   logic                         tx_load;
   logic                         tx_end;
   logic                         rx_done;
   logic                         wr_tdr;
   logic                         wr_stat;
   logic                         rd_stat;
   logic                         rd_rdr;
   logic                         tx_data_empty_flag;
   logic                         rdrf;

   assign rdata_o  = rdata_reg;
   assign txd_o    = txd_reg;
   assign sck_o    = sck_reg;
   assign sck_oe_o = sck_oe_reg;
   assign irq_o    = irq_reg;

   assign wr_tdr  = wr_i && (addr_i == spsync_pkg::OFF_TXDATA);
   assign wr_stat = wr_i && (addr_i == spsync_pkg::OFF_STATUS);
   assign rd_stat = rd_i && (addr_i == spsync_pkg::OFF_STATUS);
   assign rd_rdr  = rd_i && (addr_i == spsync_pkg::OFF_RXDATA);
   assign tx_data_empty_flag    = flag_reg[spsync_pkg::F_TX_DATA_EMPTY_FLAG];
   assign rdrf    = flag_reg[spsync_pkg::F_RDRF];

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   // Third sck stage feeds the edge detector, never the first
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rxd_s1_reg <= 1'b1;
         rxd_s2_reg <= 1'b1;
         sck_s1_reg <= 1'b1;
         sck_s2_reg <= 1'b1;
         sck_s3_reg <= 1'b1;
      end else begin
         rxd_s1_reg <= rxd_i;
         rxd_s2_reg <= rxd_s1_reg;
         sck_s1_reg <= sck_i;
         sck_s2_reg <= sck_s1_reg;
         sck_s3_reg <= sck_s2_reg;
      end
   end

   // ************************************************************
   // Clock selection and internal clock generator
   // ************************************************************
   // Sync mode with the high clock-enable bit set takes the pin
   assign int_clk = mode_reg.com && !ctrl_reg.clk_enable_bit_high;
   // One burst serves both directions, so they share one clock
   assign burst_req = (tx_state_reg != spsync_pkg::TX_IDLE) ||
                      (ctrl_reg.rx_en && !ctrl_reg.tx_en && !rdrf);
   assign div_done = (div_reg == spsync_pkg::BYTE_ZERO);

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_reg <= spsync_pkg::BAUD_RST;
      end else if (div_done) begin
         div_reg <= baud_reg;
      end else begin
         div_reg <= div_reg - 8'h01;
      end
   end

   // Pulses only while a character is pending, high otherwise
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sck_reg    <= 1'b1;
         sck_oe_reg <= 1'b0;
      end else begin
         sck_oe_reg <= int_clk;
         if (!int_clk) begin
            sck_reg <= 1'b1;
         end else if (div_done && sck_reg && burst_req) begin
            sck_reg <= 1'b0;
         end else if (div_done && !sck_reg) begin
            sck_reg <= 1'b1;
         end
      end
   end

   // External edges depend on the peer pulsing correctly
   assign fall_ev = int_clk ? (div_done && sck_reg && burst_req)
                            : (sck_s3_reg && !sck_s2_reg);
   assign rise_ev = int_clk ? (div_done && !sck_reg)
                            : (!sck_s3_reg && sck_s2_reg);

   // ************************************************************
   // Transmitter
   // ************************************************************
   assign tx_end  = (tx_state_reg == spsync_pkg::TX_FINAL) && rise_ev;
   // Reload straight after the last bit keeps characters back to back
   assign tx_load = ctrl_reg.tx_en && !tx_data_empty_flag &&
                    ((tx_state_reg == spsync_pkg::TX_IDLE) || tx_end);

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_state_reg <= spsync_pkg::TX_IDLE;
         tx_shift_reg <= spsync_pkg::BYTE_ZERO;
         tx_cnt_reg   <= spsync_pkg::CNT_ZERO;
         txd_reg      <= 1'b1;
      end else if (!ctrl_reg.tx_en) begin
         tx_state_reg <= spsync_pkg::TX_IDLE;
         tx_cnt_reg   <= spsync_pkg::CNT_ZERO;
      end else if (tx_load) begin
         tx_shift_reg <= tdr_reg;
         tx_cnt_reg   <= spsync_pkg::CNT_ZERO;
         tx_state_reg <= spsync_pkg::TX_SHIFT;
      end else if (tx_end) begin
         tx_state_reg <= spsync_pkg::TX_IDLE;
      end else if (fall_ev && tx_state_reg == spsync_pkg::TX_SHIFT) begin
         txd_reg      <= tx_shift_reg[0];
         tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
         tx_cnt_reg   <= tx_cnt_reg + spsync_pkg::CNT_ONE;
         if (tx_cnt_reg == spsync_pkg::LAST_BIT) begin
            tx_state_reg <= spsync_pkg::TX_FINAL;
         end
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tdr_reg <= spsync_pkg::BYTE_ZERO;
      end else if (wr_tdr) begin
         tdr_reg <= wdata_i;
      end
   end

   // ************************************************************
   // Receiver
   // ************************************************************
   assign rx_byte = {rxd_s2_reg, rx_shift_reg[7:1]};
   assign rx_done = rise_ev && ctrl_reg.rx_en &&
                    (rx_cnt_reg == spsync_pkg::LAST_BIT);

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_shift_reg <= spsync_pkg::BYTE_ZERO;
         rx_cnt_reg   <= spsync_pkg::CNT_ZERO;
      end else if (!ctrl_reg.rx_en) begin
         rx_cnt_reg <= spsync_pkg::CNT_ZERO;
      end else if (rise_ev) begin
         rx_shift_reg <= rx_byte;
         rx_cnt_reg   <= rx_cnt_reg + spsync_pkg::CNT_ONE;
      end
   end

   // Old byte is kept on overrun; the new one is dropped
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdr_reg  <= spsync_pkg::BYTE_ZERO;
         rx_multiproc_bit_reg <= 1'b0;
      end else if (rx_done && !rdrf) begin
         rdr_reg  <= rx_byte;
         rx_multiproc_bit_reg <= 1'b0;
      end
   end

   // ************************************************************
   // Status flags
   // ************************************************************
   // A data write beats a load so the new byte stays pending
   assign flag_set[spsync_pkg::F_TX_DATA_EMPTY_FLAG] = (tx_load && !wr_tdr) ||
                                         !ctrl_reg.tx_en;
   assign flag_set[spsync_pkg::F_RDRF] = rx_done && !rdrf;
   assign flag_set[spsync_pkg::F_OVR]  = rx_done && rdrf;
   assign flag_set[spsync_pkg::F_PER]  = rx_done && !rdrf &&
                                         mode_reg.par_en &&
                                         ((^rx_byte) != mode_reg.par_odd);
   assign flag_hw_clr[spsync_pkg::F_TX_DATA_EMPTY_FLAG] = wr_tdr;
   assign flag_hw_clr[spsync_pkg::F_RDRF] = rd_rdr;
   assign flag_hw_clr[spsync_pkg::F_OVR]  = 1'b0;
   assign flag_hw_clr[spsync_pkg::F_PER]  = 1'b0;
   assign flag_sw_clr[spsync_pkg::F_TX_DATA_EMPTY_FLAG] = !wdata_i[spsync_pkg::ST_TX_DATA_EMPTY_FLAG];
   assign flag_sw_clr[spsync_pkg::F_RDRF] = !wdata_i[spsync_pkg::ST_RDRF];
   assign flag_sw_clr[spsync_pkg::F_OVR]  = !wdata_i[spsync_pkg::ST_OVR];
   assign flag_sw_clr[spsync_pkg::F_PER]  = !wdata_i[spsync_pkg::ST_PER];

   // Clear by writing 0 only counts after the flag was read as 1
   genvar gi;
   generate
      for (gi = 0; gi < spsync_pkg::NFLAG; gi = gi + 1) begin : g_flag
         always_ff @(posedge ref_clk_i or posedge rst_i) begin
            if (rst_i) begin
               flag_reg[gi] <= spsync_pkg::FLAG_RST[gi];
               seen_reg[gi] <= 1'b0;
            end else if (flag_set[gi]) begin
               flag_reg[gi] <= 1'b1;
            end else if (flag_hw_clr[gi] ||
                         (wr_stat && flag_sw_clr[gi] && seen_reg[gi])) begin
               flag_reg[gi] <= 1'b0;
               seen_reg[gi] <= 1'b0;
            end else if (rd_stat && flag_reg[gi]) begin
               seen_reg[gi] <= 1'b1;
            end
         end
      end
   endgenerate

   // Set terms win over the clear terms
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_end_flag_reg <= 1'b1;
      end else if (!ctrl_reg.tx_en || (tx_end && tx_data_empty_flag)) begin
         tx_end_flag_reg <= 1'b1;
      end else if (wr_tdr || (wr_stat && seen_reg[spsync_pkg::F_TX_DATA_EMPTY_FLAG] &&
                              flag_sw_clr[spsync_pkg::F_TX_DATA_EMPTY_FLAG])) begin
         tx_end_flag_reg <= 1'b0;
      end
   end

   // ************************************************************
   // Interrupts
   // ************************************************************
   assign irq_ev[spsync_pkg::IRQ_TXE]  = flag_set[spsync_pkg::F_TX_DATA_EMPTY_FLAG] && !tx_data_empty_flag;
   assign irq_ev[spsync_pkg::IRQ_RXF]  = flag_set[spsync_pkg::F_RDRF];
   assign irq_ev[spsync_pkg::IRQ_TX_END_FLAG] = tx_end && tx_data_empty_flag;
   assign irq_ev[spsync_pkg::IRQ_ERR]  = flag_set[spsync_pkg::F_OVR] ||
                                         flag_set[spsync_pkg::F_PER];

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         istat_reg <= 4'h0;
      end else if (wr_i && addr_i == spsync_pkg::OFF_ISTAT) begin
         istat_reg <= (istat_reg & ~wdata_i[spsync_pkg::NIRQ-1:0]) | irq_ev;
      end else begin
         istat_reg <= istat_reg | irq_ev;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(istat_reg & imask_reg);
      end
   end

   // ************************************************************
   // Register writes and reads
   // ************************************************************
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_reg  <= spsync_pkg::CTRL_RST;
         mode_reg  <= spsync_pkg::MODE_RST;
         baud_reg  <= spsync_pkg::BAUD_RST;
         imask_reg <= 4'h0;
         tx_multiproc_bit_reg  <= 1'b0;
      end else if (wr_i) begin
         case (addr_i)
            spsync_pkg::OFF_MODE:   mode_reg  <= wdata_i[2:0];
            spsync_pkg::OFF_CTRL:   ctrl_reg  <= wdata_i[3:0];
            spsync_pkg::OFF_BAUD:   baud_reg  <= wdata_i;
            spsync_pkg::OFF_IMASK:  imask_reg <= wdata_i[spsync_pkg::NIRQ-1:0];
            spsync_pkg::OFF_STATUS:
               tx_multiproc_bit_reg <= wdata_i[spsync_pkg::ST_TX_MULTIPROC_BIT];
            default:                tx_multiproc_bit_reg  <= tx_multiproc_bit_reg;
         endcase
      end
   end

   always_comb begin
      status = spsync_pkg::BYTE_ZERO;
      status[spsync_pkg::ST_TX_DATA_EMPTY_FLAG] = tx_data_empty_flag;
      status[spsync_pkg::ST_RDRF] = rdrf;
      status[spsync_pkg::ST_OVR]  = flag_reg[spsync_pkg::F_OVR];
      status[spsync_pkg::ST_PER]  = flag_reg[spsync_pkg::F_PER];
      status[spsync_pkg::ST_TX_END_FLAG] = tx_end_flag_reg;
      status[spsync_pkg::ST_RX_MULTIPROC_BIT] = rx_multiproc_bit_reg;
      status[spsync_pkg::ST_TX_MULTIPROC_BIT] = tx_multiproc_bit_reg;
   end

   // Data stands one cycle after each cycle of read strobe, zero otherwise
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_reg <= spsync_pkg::BYTE_ZERO;
      end else if (!rd_i) begin
         rdata_reg <= spsync_pkg::BYTE_ZERO;
      end else begin
         case (addr_i)
            spsync_pkg::OFF_MODE:   rdata_reg <= {5'h00, mode_reg};
            spsync_pkg::OFF_CTRL:   rdata_reg <= {4'h0, ctrl_reg};
            spsync_pkg::OFF_TXDATA: rdata_reg <= tdr_reg;
            spsync_pkg::OFF_STATUS: rdata_reg <= status;
            spsync_pkg::OFF_RXDATA: rdata_reg <= rdr_reg;
            spsync_pkg::OFF_BAUD:   rdata_reg <= baud_reg;
            spsync_pkg::OFF_ISTAT:  rdata_reg <= {4'h0, istat_reg};
            spsync_pkg::OFF_IMASK:  rdata_reg <= {4'h0, imask_reg};
            default:                rdata_reg <= spsync_pkg::BYTE_ZERO;
         endcase
      end
   end

endmodule

`default_nettype wire

// >>> rtl/spsync_pkg.sv
// Constants, register map and types for the synchronous serial unit
package spsync_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam int          ADDR_W     = 3;
   localparam int          DATA_W     = 8;
   localparam logic [2:0]  OFF_MODE   = 3'h0;
   localparam logic [2:0]  OFF_CTRL   = 3'h1;
   localparam logic [2:0]  OFF_TXDATA = 3'h2;
   localparam logic [2:0]  OFF_STATUS = 3'h3;
   localparam logic [2:0]  OFF_RXDATA = 3'h4;
   localparam logic [2:0]  OFF_BAUD   = 3'h5;
   localparam logic [2:0]  OFF_ISTAT  = 3'h6;
   localparam logic [2:0]  OFF_IMASK  = 3'h7;

   // ************************************************************
   // Status register bit positions
   // ************************************************************
   localparam int ST_TX_DATA_EMPTY_FLAG = 7;
   localparam int ST_RDRF = 6;
   localparam int ST_OVR  = 5;
   localparam int ST_PER  = 3;
   localparam int ST_TX_END_FLAG = 2;
   localparam int ST_RX_MULTIPROC_BIT = 1;
   localparam int ST_TX_MULTIPROC_BIT = 0;

   // Index of the clear-after-read flags
   localparam int NFLAG   = 4;
   localparam int F_TX_DATA_EMPTY_FLAG  = 0;
   localparam int F_RDRF  = 1;
   localparam int F_OVR   = 2;
   localparam int F_PER   = 3;
   localparam logic [NFLAG-1:0] FLAG_RST = 4'h1;

   // Interrupt status bit positions
   localparam int NIRQ     = 4;
   localparam int IRQ_TXE  = 0;
   localparam int IRQ_RXF  = 1;
   localparam int IRQ_TX_END_FLAG = 2;
   localparam int IRQ_ERR  = 3;

   // ************************************************************
   // Reset values and counts
   // ************************************************************
   localparam logic [7:0] BAUD_RST   = 8'h04;
   localparam logic [7:0] BYTE_ZERO  = 8'h00;
   localparam logic [2:0] LAST_BIT   = 3'h7;
   localparam logic [2:0] CNT_ZERO   = 3'h0;
   localparam logic [2:0] CNT_ONE    = 3'h1;

   // ************************************************************
   // Types
   // ************************************************************
   typedef struct packed {
      logic clk_enable_bit_high;
      logic clk_enable_bit_low;
      logic rx_en;
      logic tx_en;
   } spsync_ctrl_t;

   typedef struct packed {
      logic par_odd;
      logic par_en;
      logic com;
   } spsync_mode_t;

   localparam spsync_ctrl_t CTRL_RST = 4'h0;
   localparam spsync_mode_t MODE_RST = 3'h1;

   typedef enum logic [1:0] {
      TX_IDLE  = 2'b00,
      TX_SHIFT = 2'b01,
      TX_FINAL = 2'b11
   } spsync_tx_state_t;

endpackage

// >>> verif/spsync_sva.sv
// Pin-level checks for the synchronous serial unit
`timescale 1ns/1ps
`default_nettype none
module spsync_sva (
   input wire logic                          ref_clk_i,
   input wire logic                          rst_i,
   input wire logic [spsync_pkg::ADDR_W-1:0] addr_i,
   input wire logic [spsync_pkg::DATA_W-1:0] wdata_i,
   input wire logic                          wr_i,
   input wire logic                          rd_i,
   input wire logic [spsync_pkg::DATA_W-1:0] rdata_o,
   input wire logic                          txd_o,
   input wire logic                          sck_o,
   input wire logic                          sck_oe_o
);
   // ********************
   // Shadow settings
   // ********************
   logic [7:0] baud_reg;
   logic       com_reg;
   logic       clk_enable_bit_high_reg;
   logic       txen_reg;
   logic [7:0] hi_cnt;
   logic [7:0] lo_cnt;
   logic [2:0] fall_cnt;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         baud_reg <= spsync_pkg::BAUD_RST;
         com_reg  <= 1'b1;
         clk_enable_bit_high_reg <= 1'b0;
         txen_reg <= 1'b0;
      end else if (wr_i && addr_i == spsync_pkg::OFF_BAUD) begin
         baud_reg <= wdata_i;
      end else if (wr_i && addr_i == spsync_pkg::OFF_MODE) begin
         com_reg <= wdata_i[0];
      end else if (wr_i && addr_i == spsync_pkg::OFF_CTRL) begin
         clk_enable_bit_high_reg <= wdata_i[3];
         txen_reg <= wdata_i[0];
      end
   end

   // High count saturates, so a long idle never wraps back into range
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         hi_cnt <= 8'h00;
         lo_cnt <= 8'h00;
      end else begin
         hi_cnt <= sck_o ? hi_cnt + {7'h00, ~&hi_cnt} : 8'h00;
         lo_cnt <= sck_o ? 8'h00 : lo_cnt + 8'h01;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fall_cnt <= 3'h0;
      end else if (sck_oe_o && $fell(sck_o)) begin
         fall_cnt <= fall_cnt + 3'h1;
      end
   end

   // ********************
   // Properties
   // ********************
   a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data not zero outside a read answer");
   a_tx_on_fall: assert property (
      sck_oe_o && $past(sck_oe_o) && txen_reg && $past(txen_reg)
      && $changed(txd_o) |-> $fell(sck_o))
      else $error("transmit line moved off a falling clock edge");
   a_low_phase: assert property (
      sck_oe_o && $rose(sck_o) |-> lo_cnt == baud_reg + 8'h01)
      else $error("clock low phase differs from divider setting");
   a_idle_whole: assert property (
      sck_oe_o && hi_cnt > baud_reg + 8'h02 |-> fall_cnt == 3'h0)
      else $error("clock idled in the middle of a character");
   a_msb_hold: assert property (
      sck_oe_o && txen_reg && hi_cnt > baud_reg + 8'h02 |-> $stable(txd_o))
      else $error("transmit line moved while the clock idled");
   a_clk_pin_sel: assert property (
      wr_i && (addr_i == spsync_pkg::OFF_CTRL
      || addr_i == spsync_pkg::OFF_MODE)
      |=> ##1 sck_oe_o == (com_reg && !clk_enable_bit_high_reg))
      else $error("clock pin drive does not follow the source");
endmodule

bind spsync_top spsync_sva u_sva (
   .ref_clk_i (ref_clk_i),
   .rst_i     (rst_i),
   .addr_i    (addr_i),
   .wdata_i   (wdata_i),
   .wr_i      (wr_i),
   .rd_i      (rd_i),
   .rdata_o   (rdata_o),
   .txd_o     (txd_o),
   .sck_o     (sck_o),
   .sck_oe_o  (sck_oe_o)
);
`default_nettype wire

// >>> verif/spsync_peer.sv
// Serial peer on the data and clock lines of the unit
`timescale 1ns/1ps
`default_nettype none
module spsync_peer (
   input  wire logic sck_w_i,
   input  wire logic txd_i,
   output logic      rxd_o,
   output logic      sck_o,
   output logic      sck_oe_o
);
   // ********************
   // Frame engine
   // ********************
   logic [7:0] send_q[$];
   logic [7:0] got_q[$];
   logic [7:0] cur;
   logic [7:0] shreg;
   int         fcnt;
   int         rcnt;

   initial begin
      rxd_o = 1'b1;
      sck_o = 1'b1;
      sck_oe_o = 1'b0;
      cur = 8'hFF;
      fcnt = 0;
      rcnt = 0;
   end

   // New bit on each falling edge, LSB first
   always @(negedge sck_w_i) begin
      if (fcnt == 0) begin
         cur = (send_q.size() > 0) ? send_q.pop_front() : 8'hFF;
      end
      rxd_o <= cur[fcnt];
      fcnt = (fcnt + 1) % 8;
   end

   // Late in the high phase: the pin sync delays the external case
   always @(posedge sck_w_i) begin
      #60;
      shreg = {txd_i, shreg[7:1]};
      rcnt = rcnt + 1;
      if (rcnt == 8) begin
         got_q.push_back(shreg);
         rcnt = 0;
      end
   end

   // Eight pulses, idle high outside the frame
   // Edges land on clock edges, so non-blocking avoids a sampling race
   task automatic ext_frame();
      sck_oe_o <= 1'b1;
      repeat (8) begin
         #80 sck_o <= 1'b0;
         #80 sck_o <= 1'b1;
      end
      #80 sck_oe_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> verif/spsync_top_test.sv
// Self-checking bench for the synchronous serial unit
`timescale 1ns/1ps
`default_nettype none
module spsync_top_test;
   // ********************
   // Wiring
   // ********************
   logic       ref_clk_i;
   logic       rst_i;
   logic [2:0] addr_i;
   logic [7:0] wdata_i;
   logic       wr_i;
   logic       rd_i;
   logic [7:0] rdata_o;
   logic       txd_o;
   logic       rxd_w;
   logic       sck_o;
   logic       sck_oe_o;
   logic       irq_o;
   logic       peer_sck;
   logic       peer_oe;
   int         err_total;
   int         tests_run;
   int         cyc;
   logic [7:0] d;
   logic [7:0] p;
   logic [7:0] exp_q[$];
   wire logic  sck_w;

   // Pull-up keeps the clock pin high when nobody drives it
   assign sck_w = sck_oe_o ? sck_o : (peer_oe ? peer_sck : 1'b1);

   spsync_top uut (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .addr_i    (addr_i),
      .wdata_i   (wdata_i),
      .wr_i      (wr_i),
      .rd_i      (rd_i),
      .rdata_o   (rdata_o),
      .txd_o     (txd_o),
      .rxd_i     (rxd_w),
      .sck_i     (sck_w),
      .sck_o     (sck_o),
      .sck_oe_o  (sck_oe_o),
      .irq_o     (irq_o)
   );

   spsync_peer peer (
      .sck_w_i  (sck_w),
      .txd_i    (txd_o),
      .rxd_o    (rxd_w),
      .sck_o    (peer_sck),
      .sck_oe_o (peer_oe)
   );

   // ********************
   // Tasks
   // ********************
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge ref_clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Bounded wait for a status bit to rise
   task automatic poll(input int b);
      rd(spsync_pkg::OFF_STATUS, d);
      for (int n = 0; n < 300 && d[b] !== 1'b1; n++) begin
         rd(spsync_pkg::OFF_STATUS, d);
      end
      chk({7'h00, d[b]}, 8'h01);
   endtask

   // Realigns the peer after frames it was not meant to count
   task automatic peer_sync();
      peer.fcnt = 0;
      peer.rcnt = 0;
      peer.got_q.delete();
   endtask

   task automatic end_of_test();
      if (err_total == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ********************
   // Clock, timeout, tests
   // ********************
   initial begin
      ref_clk_i = 1'b0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end

   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         end_of_test();
      end
   end

   initial begin
      rst_i = 1'b1;
      addr_i = 3'h0;
      wdata_i = 8'h00;
      wr_i = 1'b0;
      rd_i = 1'b0;
      err_total = 0;
      tests_run = 0;
      cyc = 0;
      p = 8'($urandom(86210));
      repeat (20) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      rd(spsync_pkg::OFF_MODE, d);
      chk(d, 8'h01);
      rd(spsync_pkg::OFF_STATUS, d);
      chk(d, 8'h84);
      rd(spsync_pkg::OFF_BAUD, d);
      chk(d, 8'h04);
      peer_sync();
      wr(spsync_pkg::OFF_CTRL, 8'h01);
      for (int i = 0; i < 2; i++) begin
         exp_q.push_back(8'($urandom));
         wr(spsync_pkg::OFF_TXDATA, exp_q[i]);
         rd(spsync_pkg::OFF_STATUS, d);
         chk({7'h00, d[2]}, 8'h00);
         poll(7);
      end
      poll(2);
      repeat (5) @(posedge ref_clk_i);
      foreach (exp_q[i]) chk(peer.got_q[i], exp_q[i]);
      chk({7'h00, txd_o}, {7'h00, exp_q[1][7]});
      wr(spsync_pkg::OFF_CTRL, 8'h00);
      rd(spsync_pkg::OFF_STATUS, d);
      chk({7'h00, d[2]}, 8'h01);
      // Odd weight so the even setting must flag it
      p[0] = ~^p[7:1];
      peer.send_q.push_back(p);
      wr(spsync_pkg::OFF_BAUD, 8'h06);
      rd(spsync_pkg::OFF_BAUD, d);
      chk(d, 8'h06);
      wr(spsync_pkg::OFF_MODE, 8'h03);
      wr(spsync_pkg::OFF_IMASK, 8'h02);
      wr(spsync_pkg::OFF_CTRL, 8'h02);
      poll(6);
      chk({7'h00, d[3]}, {7'h00, ^p});
      chk({7'h00, d[1]}, 8'h00);
      chk({7'h00, irq_o}, 8'h01);
      wr(spsync_pkg::OFF_STATUS, 8'hF1);
      rd(spsync_pkg::OFF_STATUS, d);
      chk({6'h00, d[3], d[0]}, 8'h01);
      wr(spsync_pkg::OFF_ISTAT, 8'h02);
      repeat (2) @(posedge ref_clk_i);
      #1 chk({7'h00, irq_o}, 8'h00);
      wr(spsync_pkg::OFF_CTRL, 8'h0B);
      repeat (2) @(posedge ref_clk_i);
      #1 chk({7'h00, sck_oe_o}, 8'h00);
      // Sync mode bit off alone must also pick the pin clock
      wr(spsync_pkg::OFF_MODE, 8'h06);
      wr(spsync_pkg::OFF_CTRL, 8'h03);
      rd(spsync_pkg::OFF_RXDATA, d);
      chk(d, p);
      peer_sync();
      for (int i = 0; i < 2; i++) begin
         exp_q[i] = 8'($urandom);
         p = 8'($urandom);
         peer.send_q.push_back(p);
         wr(spsync_pkg::OFF_TXDATA, exp_q[i]);
         repeat (4) @(posedge ref_clk_i);
         peer.ext_frame();
         poll(6);
         rd(spsync_pkg::OFF_RXDATA, d);
         chk(d, p);
      end
      repeat (5) @(posedge ref_clk_i);
      foreach (exp_q[i]) chk(peer.got_q[i], exp_q[i]);
      end_of_test();
   end
endmodule
`default_nettype wire
